// ==== tmal_pkg.sv ====
package tmal_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ACC_W  = 32;
	localparam int DATA_W = 16;
	localparam int PMA_W  = 12;
	localparam int DMA_W  = 8;
	localparam int OFS_W  = 7;
	localparam int STK_DEPTH = 4;

	// ----------------------------------------
	// Opcode patterns (bits 15..8; OPC_ZAC is the whole 16-bit word)
	// ----------------------------------------
	localparam logic [7:0] OPC_SUB_UNSIGNED_OP = 8'h64;
	localparam logic [7:0] OPC_TABLE_READ_OP = 8'h67;
	localparam logic [7:0] OPC_TABLE_WRITE_OP = 8'h7D;
	localparam logic [7:0] OPC_XOR  = 8'h78;
	localparam logic [7:0] OPC_ZERO_LOW_LOAD_HIGH_OP = 8'h65;
	localparam logic [7:0] OPC_ZERO_HIGH_LOAD_LOW_OP = 8'h66;
	localparam logic [15:0] OPC_ZAC = 16'h7F89;

	// ----------------------------------------
	// Instruction field positions
	// ----------------------------------------
	localparam int IND_BIT    = 7;
	localparam int IMOD_LO    = 4;
	localparam int NARP_EN    = 3;
	localparam int NARP_BIT   = 0;

	// ----------------------------------------
	// Reset values and saturation limits
	// ----------------------------------------
	localparam logic [31:0] ACC_RST = 32'h00000000;
	localparam logic [11:0] PC_RST  = 12'h000;
	localparam logic [31:0] SAT_POS = 32'h7FFFFFFF;
	localparam logic [31:0] SAT_NEG = 32'h80000000;
	localparam int TBL_CYCLES = 3;

	typedef enum logic [1:0] {
		TMAL_IDLE = 2'b00,
		TMAL_MEM1 = 2'b01,
		TMAL_MEM2 = 2'b10
	} tmal_state_t;
endpackage : tmal_pkg

// ==== tmal_addr_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Data address former and pointer update
// ----------------------------------------
module tmal_addr_gen
	import tmal_pkg::*;
(
	input  wire logic [15:0]     instr_i,        // Instruction word
	input  wire logic            page_pointer_i, // Page pointer bit
	input  wire logic            aux_reg_pointer_i, // Current pointer
	input  wire logic [DMA_W-1:0] aux0_i,        // Aux register 0
	input  wire logic [DMA_W-1:0] aux1_i,        // Aux register 1
	output logic      [DMA_W-1:0] dma_o,         // Formed address
	output logic      [DMA_W-1:0] aux_new_o,     // Post-modified aux value
	output logic                 aux_upd_o,      // Aux write wanted
	output logic                 next_arp_o      // Pointer after instruction
);
	logic [DMA_W-1:0] sel;

	// Direct uses page bit and offset; indirect uses the pointed aux
	always_comb
	begin
		sel        = aux_reg_pointer_i ? aux1_i : aux0_i;
		dma_o      = instr_i[IND_BIT] ? sel : {page_pointer_i, instr_i[OFS_W-1:0]};
		aux_upd_o  = 1'b0;
		aux_new_o  = sel;
		next_arp_o = aux_reg_pointer_i;
		if (instr_i[IND_BIT])
		begin
			// Bit 5 = increment, bit 4 = decrement, applied after access
			if (instr_i[5])
			begin
				aux_new_o = sel + 8'h01;
				aux_upd_o = 1'b1;
			end
			else if (instr_i[IMOD_LO])
			begin
				aux_new_o = sel - 8'h01;
				aux_upd_o = 1'b1;
			end
			if (!instr_i[NARP_EN])
				next_arp_o = instr_i[NARP_BIT]; // Only AR0/AR1 selectable
		end
	end
endmodule : tmal_addr_gen
`default_nettype wire

// ==== tmal_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmal_core
	import tmal_pkg::*;
(
	input  wire logic              sys_clk_i,        // 10 MHz clock
	input  wire logic              nrst_i,           // Async reset, active low
	input  wire logic [15:0]       instr_i,          // Fetched instruction
	input  wire logic              instr_valid_i,    // Instruction offered
	input  wire logic              saturate_mode_bit_i, // Saturation enable
	input  wire logic              page_pointer_i,   // Data page bit
	input  wire logic [DATA_W-1:0] dmem_rdata_i,     // Data memory read word
	input  wire logic [DATA_W-1:0] pmem_rdata_i,     // Program memory read word
	output logic                   busy_o,           // Table move in progress
	output logic [PMA_W-1:0]       pc_o,             // Program counter
	output logic [ACC_W-1:0]       accumulator_o,    // Accumulator
	output logic                   overflow_flag_o,  // Sticky overflow flag
	output logic                   aux_reg_pointer_o, // Aux register pointer
	output logic [DMA_W-1:0]       aux0_o,           // Aux register 0
	output logic [DMA_W-1:0]       aux1_o,           // Aux register 1
	output logic [PMA_W-1:0]       stack_top_o,      // Top of stack
	output logic [DMA_W-1:0]       dmem_addr_o,      // Data memory address
	output logic                   dmem_rd_o,        // Data memory read strobe
	output logic                   dmem_wr_o,        // Data memory write strobe
	output logic [DATA_W-1:0]      dmem_wdata_o,     // Data memory write word
	output logic [PMA_W-1:0]       pmem_addr_o,      // Program memory address
	output logic                   pmem_rd_o,        // Program memory read strobe
	output logic                   pmem_wr_o,        // Program memory write strobe
	output logic [DATA_W-1:0]      pmem_wdata_o      // Program memory write word
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		tmal_state_t      st;
		logic             bsy;
		logic             is_table_write_op;
		logic [PMA_W-1:0] pc;
		logic [ACC_W-1:0] acc;
		logic             ov;
		logic             aux_reg_pointer;
		logic [DMA_W-1:0] ar0;
		logic [DMA_W-1:0] ar1;
		logic [STK_DEPTH-1:0][PMA_W-1:0] stk;
		logic [DMA_W-1:0]  lat_dma;
		logic [DMA_W-1:0]  lat_aux;
		logic              lat_aupd;
		logic              lat_narp;
		logic [DMA_W-1:0]  daddr;
		logic              drd;
		logic              dwr;
		logic [DATA_W-1:0] dwdata;
		logic [PMA_W-1:0]  paddr;
		logic              prd;
		logic              pwr;
		logic [DATA_W-1:0] pwdata;
	} tmal_regs_t;

	tmal_regs_t r;
	tmal_regs_t next_r;

	logic [DMA_W-1:0] ag_dma;
	logic [DMA_W-1:0] ag_aux;
	logic             ag_upd;
	logic             ag_narp;

	// Operand is the memory word present in the decode cycle
	logic [32:0] diff;
	logic        sub_ovf;

	// ----------------------------------------
	// Address generation
	// ----------------------------------------
	tmal_addr_gen u_addr
	(
		.instr_i           (instr_i),
		.page_pointer_i    (page_pointer_i),
		.aux_reg_pointer_i (r.aux_reg_pointer),
		.aux0_i            (r.ar0),
		.aux1_i            (r.ar1),
		.dma_o             (ag_dma),
		.aux_new_o         (ag_aux),
		.aux_upd_o         (ag_upd),
		.next_arp_o        (ag_narp)
	);

	// Applies post-modify of the pointed aux register and pointer change
	function automatic tmal_regs_t apply_ptr(input tmal_regs_t s, input logic upd,
		input logic [DMA_W-1:0] val, input logic narp);
		tmal_regs_t t;
		t = s;
		if (upd)
		begin
			if (s.aux_reg_pointer)
				t.ar1 = val;
			else
				t.ar0 = val;
		end
		t.aux_reg_pointer = narp;
		return t;
	endfunction : apply_ptr

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		next_r      = r;
		next_r.drd  = 1'b0;
		next_r.dwr  = 1'b0;
		next_r.prd  = 1'b0;
		next_r.pwr  = 1'b0;
		// Sign-extend accumulator, zero-extend operand to 33 bits
		diff    = 33'({r.acc[31], r.acc} - {17'h00000, dmem_rdata_i});
		sub_ovf = r.acc[31] & ~diff[31];
		unique case (r.st)
			TMAL_IDLE:
			begin
				if (instr_valid_i)
				begin
					next_r.pc = r.pc + 12'h001;
					if (instr_i[15:8] == OPC_SUB_UNSIGNED_OP)
					begin
						if (sub_ovf)
						begin
							next_r.ov  = 1'b1;
							next_r.acc = saturate_mode_bit_i ? SAT_NEG : diff[31:0];
						end
						else
							next_r.acc = diff[31:0];
						next_r = apply_ptr(next_r, ag_upd, ag_aux, ag_narp);
					end
					else if (instr_i[15:8] == OPC_XOR)
					begin
						next_r.acc = {r.acc[31:16], r.acc[15:0] ^ dmem_rdata_i};
						next_r = apply_ptr(next_r, ag_upd, ag_aux, ag_narp);
					end
					else if (instr_i == OPC_ZAC)
						next_r.acc = ACC_RST;
					else if (instr_i[15:8] == OPC_ZERO_LOW_LOAD_HIGH_OP)
					begin
						next_r.acc = {dmem_rdata_i, 16'h0000};
						next_r = apply_ptr(next_r, ag_upd, ag_aux, ag_narp);
					end
					else if (instr_i[15:8] == OPC_ZERO_HIGH_LOAD_LOW_OP)
					begin
						next_r.acc = {16'h0000, dmem_rdata_i};
						next_r = apply_ptr(next_r, ag_upd, ag_aux, ag_narp);
					end
					else if (instr_i[15:8] == OPC_TABLE_READ_OP || instr_i[15:8] == OPC_TABLE_WRITE_OP)
					begin
						// Push PC+1; deepest entry lost, copies the one above
						next_r.stk[0] = r.pc + 12'h001;
						next_r.stk[1] = r.stk[0];
						next_r.stk[2] = r.stk[1];
						next_r.stk[3] = r.stk[2];
						next_r.pc       = r.acc[PMA_W-1:0];
						next_r.is_table_write_op  = (instr_i[15:8] == OPC_TABLE_WRITE_OP);
						next_r.lat_dma  = ag_dma;
						next_r.lat_aux  = ag_aux;
						next_r.lat_aupd = ag_upd;
						next_r.lat_narp = ag_narp;
						next_r.st       = TMAL_MEM1;
						if (instr_i[15:8] == OPC_TABLE_WRITE_OP)
						begin
							next_r.daddr = ag_dma; // Data read first
							next_r.drd   = 1'b1;
						end
						else
						begin
							next_r.paddr = r.acc[PMA_W-1:0];
							next_r.prd   = 1'b1;
						end
					end
				end
			end
			TMAL_MEM1:
			begin
				next_r.st = TMAL_MEM2;
				if (r.is_table_write_op)
				begin
					next_r.paddr  = r.pc;
					next_r.pwdata = dmem_rdata_i;
					next_r.pwr    = 1'b1;
				end
				else
				begin
					next_r.daddr  = r.lat_dma;
					next_r.dwdata = pmem_rdata_i;
					next_r.dwr    = 1'b1;
				end
			end
			TMAL_MEM2:
			begin
				// Third cycle: restore PC from stack top, pop
				next_r.pc     = r.stk[0];
				next_r.stk[0] = r.stk[1];
				next_r.stk[1] = r.stk[2];
				next_r.stk[2] = r.stk[3];
				next_r.st     = TMAL_IDLE;
				next_r = apply_ptr(next_r, r.lat_aupd, r.lat_aux, r.lat_narp);
			end
			default:
				next_r.st = TMAL_IDLE;
		endcase
		// Busy kept as its own flop so the port has no decode behind it
		next_r.bsy = (next_r.st != TMAL_IDLE);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			r        <= '0;
			r.st     <= TMAL_IDLE;
			r.pc     <= PC_RST;
			r.acc    <= ACC_RST;
		end
		else
			r <= next_r;
	end

	// Outputs straight from flip-flops
	assign busy_o            = r.bsy;
	assign pc_o              = r.pc;
	assign accumulator_o     = r.acc;
	assign overflow_flag_o   = r.ov;
	assign aux_reg_pointer_o = r.aux_reg_pointer;
	assign aux0_o            = r.ar0;
	assign aux1_o            = r.ar1;
	assign stack_top_o       = r.stk[0];
	assign dmem_addr_o       = r.daddr;
	assign dmem_rd_o         = r.drd;
	assign dmem_wr_o         = r.dwr;
	assign dmem_wdata_o      = r.dwdata;
	assign pmem_addr_o       = r.paddr;
	assign pmem_rd_o         = r.prd;
	assign pmem_wr_o         = r.pwr;
	assign pmem_wdata_o      = r.pwdata;
endmodule : tmal_core
`default_nettype wire

// ==== tmal_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Accumulator and table move checks
// ----------------------------------------
module tmal_core_props
	import tmal_pkg::*;
(
	input wire logic              sys_clk_i,       // Clock
	input wire logic              nrst_i,          // Reset
	input wire logic [15:0]       instr_i,         // Instruction
	input wire logic              instr_valid_i,   // Offered
	input wire logic [DATA_W-1:0] dmem_rdata_i,    // Data word
	input wire logic [DATA_W-1:0] pmem_rdata_i,    // Program word
	input wire logic              busy_o,          // Busy
	input wire logic [PMA_W-1:0]  pc_o,            // PC
	input wire logic [ACC_W-1:0]  accumulator_o,   // Accumulator
	input wire logic              overflow_flag_o, // Overflow
	input wire logic              dmem_rd_o,       // Data read
	input wire logic              dmem_wr_o,       // Data write
	input wire logic [DATA_W-1:0] dmem_wdata_o,    // Data wdata
	input wire logic [PMA_W-1:0]  pmem_addr_o,     // Program addr
	input wire logic              pmem_rd_o,       // Program read
	input wire logic              pmem_wr_o,       // Program write
	input wire logic [DATA_W-1:0] pmem_wdata_o     // Program wdata
);
	// Accepted requests only; anything offered while busy is ignored
	wire tk = instr_valid_i & ~busy_o;
	wire rd = tk & (instr_i[15:8] == OPC_TABLE_READ_OP);
	wire wr = tk & (instr_i[15:8] == OPC_TABLE_WRITE_OP);
	wire sg = tk & ~rd & ~wr;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_busy; (rd | wr) |=> busy_o [*2] ##1 !busy_o; endproperty
	a_busy: assert property (p_busy) else $error("table move length wrong");
	property p_table_read_op; rd |=> pmem_rd_o && pmem_addr_o == $past(accumulator_o[11:0])
		##1 dmem_wr_o && dmem_wdata_o == $past(pmem_rdata_i); endproperty
	a_table_read_op: assert property (p_table_read_op) else $error("table read transfer wrong");
	property p_table_write_op; wr |=> dmem_rd_o && !pmem_wr_o ##1 pmem_wr_o && pmem_wdata_o == $past(dmem_rdata_i)
		&& pmem_addr_o == $past(accumulator_o[11:0], 2); endproperty
	a_table_write_op: assert property (p_table_write_op) else $error("table write transfer wrong");
	property p_pc; (rd | wr) |=> pc_o == $past(accumulator_o[11:0]) ##2 pc_o == $past(pc_o, 3) + 12'h001; endproperty
	a_pc: assert property (p_pc) else $error("table pc handling wrong");
	property p_one; sg |=> pc_o == $past(pc_o) + 12'h001 && !busy_o; endproperty
	a_one: assert property (p_one) else $error("single op pc wrong");
	property p_zac; tk && instr_i == OPC_ZAC |=> accumulator_o == ACC_RST; endproperty
	a_zac: assert property (p_zac) else $error("clear failed");
	property p_xor; tk && instr_i[15:8] == OPC_XOR |=> accumulator_o ==
		{$past(accumulator_o[31:16]), $past(accumulator_o[15:0]) ^ $past(dmem_rdata_i)}; endproperty
	a_xor: assert property (p_xor) else $error("xor result wrong");
	property p_zero_low_load_high_op; tk && instr_i[15:8] == OPC_ZERO_LOW_LOAD_HIGH_OP |=> accumulator_o == {$past(dmem_rdata_i), 16'h0000}; endproperty
	a_zero_low_load_high_op: assert property (p_zero_low_load_high_op) else $error("load high wrong");
	property p_ov; $rose(overflow_flag_o) |-> $past(tk) && $past(instr_i[15:8]) == OPC_SUB_UNSIGNED_OP; endproperty
	a_ov: assert property (p_ov) else $error("overflow set by wrong op");
endmodule : tmal_core_props
bind tmal_core tmal_core_props i_tmal_core_props (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
	.dmem_rdata_i(dmem_rdata_i), .pmem_rdata_i(pmem_rdata_i), .busy_o(busy_o), .pc_o(pc_o),
	.accumulator_o(accumulator_o), .overflow_flag_o(overflow_flag_o), .dmem_rd_o(dmem_rd_o),
	.dmem_wr_o(dmem_wr_o), .dmem_wdata_o(dmem_wdata_o), .pmem_addr_o(pmem_addr_o),
	.pmem_rd_o(pmem_rd_o), .pmem_wr_o(pmem_wr_o), .pmem_wdata_o(pmem_wdata_o)
);
`default_nettype wire

// ==== tmal_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Program and data memory model
// ----------------------------------------
module tmal_mem_model
	import tmal_pkg::*;
(
	input wire logic              sys_clk_i,    // Clock
	input wire logic [DATA_W-1:0] op_i,         // Operand word
	input wire logic [DMA_W-1:0]  dmem_addr_i,  // Data addr
	input wire logic              dmem_rd_i,    // Data read
	input wire logic              dmem_wr_i,    // Data write
	input wire logic [DATA_W-1:0] dmem_wdata_i, // Data wdata
	input wire logic [PMA_W-1:0]  pmem_addr_i,  // Program addr
	input wire logic              pmem_rd_i,    // Program read
	input wire logic              pmem_wr_i,    // Program write
	input wire logic [DATA_W-1:0] pmem_wdata_i, // Program wdata
	output logic     [DATA_W-1:0] dmem_rdata_o, // Data word
	output logic     [DATA_W-1:0] pmem_rdata_o  // Program word
);
	logic [DATA_W-1:0] dmem [256];
	logic [DATA_W-1:0] pmem [4096];
	logic [DATA_W-1:0] noise = 16'h5A5A;
	// Idle program read line toggles so a stale word never passes for valid
	always @(posedge sys_clk_i)
	begin
		noise <= ~noise;
		if (dmem_wr_i)
			dmem[dmem_addr_i] <= dmem_wdata_i;
		if (pmem_wr_i)
			pmem[pmem_addr_i] <= pmem_wdata_i;
	end
	// Single ops see the operand word; table writes see the data array
	assign dmem_rdata_o = dmem_rd_i ? dmem[dmem_addr_i] : op_i;
	assign pmem_rdata_o = pmem_rd_i ? pmem[pmem_addr_i] : noise;
endmodule : tmal_mem_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module testbench
	import tmal_pkg::*;
;
	logic        sys_clk_i = 0, nrst_i = 0, valid = 0, sat = 0, pp = 0;
	logic [15:0] instr = 16'h0000, op = 16'h0000, seed = 16'hC7FE;
	logic        busy, ov, dr, dw, pr, pw, exp_ov = 0;
	logic [11:0] pc, stack_top, pa, exp_pc = 12'h000;
	logic [31:0] acc, exp_acc = 32'h0;
	logic [7:0]  da;
	logic [15:0] drd, prd, dwd, pwd;
	logic [7:0]  opc [4] = '{OPC_SUB_UNSIGNED_OP, OPC_XOR, OPC_ZERO_LOW_LOAD_HIGH_OP, OPC_ZERO_HIGH_LOAD_LOW_OP};
	int          error_cnt = 0, cmp_count = 0, cyc = 0;
	tmal_core i_tmal_core (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .instr_i(instr), .instr_valid_i(valid),
		.saturate_mode_bit_i(sat), .page_pointer_i(pp), .dmem_rdata_i(drd), .pmem_rdata_i(prd),
		.busy_o(busy), .pc_o(pc), .accumulator_o(acc), .overflow_flag_o(ov), .aux_reg_pointer_o(),
		.aux0_o(), .aux1_o(), .stack_top_o(stack_top), .dmem_addr_o(da), .dmem_rd_o(dr), .dmem_wr_o(dw),
		.dmem_wdata_o(dwd), .pmem_addr_o(pa), .pmem_rd_o(pr), .pmem_wr_o(pw), .pmem_wdata_o(pwd)
	);
	tmal_mem_model i_tmal_mem_model (
		.sys_clk_i(sys_clk_i), .op_i(op), .dmem_addr_i(da), .dmem_rd_i(dr), .dmem_wr_i(dw),
		.dmem_wdata_i(dwd), .pmem_addr_i(pa), .pmem_rd_i(pr), .pmem_wr_i(pw), .pmem_wdata_i(pwd),
		.dmem_rdata_o(drd), .pmem_rdata_o(prd)
	);
	always #50 sys_clk_i = ~sys_clk_i;
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	// Expected {overflow, accumulator}; overflow only from a negative start
	function automatic logic [32:0] f_exp(input logic [15:0] i, input logic [31:0] a, input logic [15:0] d,
		input logic s);
		logic [31:0] r;
		r = a - {16'h0000, d};
		case (i[15:8])
			OPC_SUB_UNSIGNED_OP: return (a[31] & ~r[31]) ? {1'b1, s ? SAT_NEG : r} : {1'b0, r};
			OPC_XOR:  return {1'b0, a[31:16], a[15:0] ^ d};
			OPC_ZERO_LOW_LOAD_HIGH_OP: return {1'b0, d, 16'h0000};
			OPC_ZERO_HIGH_LOAD_LOW_OP: return {1'b0, 16'h0000, d};
			default:  return {1'b0, (i == OPC_ZAC) ? 32'h0 : a};
		endcase
	endfunction : f_exp
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// Offer one instruction; a table move keeps a clear offered while busy
	task automatic exec(input logic [15:0] i, input logic [15:0] d, input logic s);
		logic [32:0] r;
		instr <= i;
		op <= d;
		sat <= s;
		valid <= 1'b1;
		@(posedge sys_clk_i);
		r = f_exp(i, exp_acc, d, s);
		exp_acc = r[31:0];
		exp_ov = exp_ov | r[32];
		exp_pc = exp_pc + 12'h001;
		if (i[15:8] == OPC_TABLE_READ_OP || i[15:8] == OPC_TABLE_WRITE_OP)
		begin
			instr <= OPC_ZAC;
			repeat (2) @(posedge sys_clk_i);
		end
	endtask : exec
	// Idle-cycle compare with stack top expected zero, stack top against expected PC while busy, half a period away from the launching edge
	always @(negedge sys_clk_i)
		if (nrst_i && !busy)
		begin
			chk("acc", acc, exp_acc);
			chk("pc", {20'h0, pc}, {20'h0, exp_pc});
			chk("ovf", {31'h0, ov}, {31'h0, exp_ov});
			chk("tos", {20'h0, stack_top}, 32'h0);
		end
		else if (nrst_i)
			chk("tos_busy", {20'h0, stack_top}, {20'h0, exp_pc});
	// Hang guard, far above the fewer than a hundred cycles needed
	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			error_cnt++;
			results();
		end
	end
	initial
	begin
		repeat (20) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		@(posedge sys_clk_i);
		exec({OPC_ZERO_LOW_LOAD_HIGH_OP, 8'h00}, 16'h8000, 1'b0);
		exec({OPC_SUB_UNSIGNED_OP, 8'h01}, 16'h0001, 1'b0);
		exec({OPC_ZERO_LOW_LOAD_HIGH_OP, 8'h00}, 16'h8000, 1'b1);
		exec({OPC_SUB_UNSIGNED_OP, 8'h01}, 16'hFFFF, 1'b1);
		$display("overflow corner test done");
		repeat (60)
		begin
			seed = lfsr(seed);
			pp <= seed[6];
			exec((seed[3:0] == 4'h0) ? OPC_ZAC : {opc[seed[5:4]], seed[15:8]}, lfsr(seed), seed[7]);
		end
		$display("random op test done");
		i_tmal_mem_model.pmem[12'hFFF] = 16'h3C5A;
		i_tmal_mem_model.dmem[8'h80] = 16'hA55A;
		exec({OPC_ZERO_HIGH_LOAD_LOW_OP, 8'h00}, 16'hFFFF, 1'b0);
		pp <= 1'b1;
		exec({OPC_TABLE_READ_OP, 8'h7F}, 16'h0000, 1'b0);
		exec({OPC_TABLE_WRITE_OP, 8'h00}, 16'h0000, 1'b0);
		valid <= 1'b0;
		@(negedge sys_clk_i);
		chk("dmem", {16'h0, i_tmal_mem_model.dmem[8'hFF]}, 32'h3C5A);
		chk("pmem", {16'h0, i_tmal_mem_model.pmem[12'hFFF]}, 32'hA55A);
		$display("table move test done");
		results();
	end
endmodule : testbench
`default_nettype wire
